// ---- rtl/jdhp_tap.v ----
// debug test access port with halt-mode entry and exit
`timescale 1ns/1ps
`include "jdhp_defs.vh"

// Notes on behaviour
// - halt mode bit 30 of status register is writable only from the scan port
// - with halt mode on, listed debug events halt the core instead of excepting
// - scanned halt takes effect only on entry to run-test/idle
// - core-halted flag set on entry to debug state
// - in debug state pc held, interrupts ignored, fetch from transfer register
// - restart resumes the core only when run-test/idle is next entered
// - halted flag cleared before restart; restarted flag set once done
// - four-bit instruction register, identification and bypass registers
// - instruction codes decode as the standard table of eleven codes
// - undefined instruction codes behave as bypass
// - extest writes the selected chain; c1, c4, c5 written this way
// - extest captures inputs, shifts, drives outputs at update
// - intest reads the selected chain; c0, c1, c4, c5 captured and shifted out
// - intest shift discards incoming bits and never alters chain contents
// - chain-select register captures fixed pattern 1000
// - chain number takes effect at update and holds until next selection
// - after reset chain 3 is selected
// - restart leaves the chain-select register unchanged
// - halt instruction halts only with halt mode enabled
// - idcode captures device code, shifts with tdi in, unchanged at update
// - bypass captures 0, one-bit delay, no effect at update or on pins
// - sample, clamp, highz, clamp-float act as bypass on internal chains
// - id code: version 31:28, part 27:12, maker 11:1, bit 0 marker
module jdhp_tap #(
    parameter [31:0] IDCODE_VALUE   = 32'h1000_0001, // arbitrary identity value
    parameter [31:0] DEBUG_ID_VALUE = 32'h0000_0010, // arbitrary identity value
    parameter        BSCAN_W        = 8
) (
    input  wire               sys_clk_i,
    input  wire               reset_n_i,
    input  wire               tck_i,
    input  wire               tms_i,
    input  wire               tdi_i,
    output wire               tdo_o,
    output wire               tdo_oe_n_o,
    input  wire               external_debug_request_i,
    input  wire               vector_catch_i,
    input  wire               reg_breakpoint_hit_i,
    input  wire               watchpoint_hit_i,
    input  wire               breakpoint_instruction_i,
    input  wire [31:0]        dtr_core_data_i,
    input  wire [BSCAN_W-1:0] bscan_in_i,
    output wire [BSCAN_W-1:0] bscan_out_o,
    output wire               bscan_test_mode_o,
    output wire               debug_state_o,
    output wire               sw_exception_o,
    output wire [31:0]        itr_data_o,
    output wire               itr_valid_o,
    output wire [31:0]        dtr_data_o,
    output wire               dtr_valid_o
);

    localparam [31:0] BSCAN_W32 = BSCAN_W;
    localparam [5:0]  BSCAN_LEN = BSCAN_W32[5:0];

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function [3:0] tap_next;
        input [3:0] st;
        input       tms;
        begin
            case (st)
                `JDHP_TLR:    tap_next = tms ? `JDHP_TLR    : `JDHP_RTI;
                `JDHP_RTI:    tap_next = tms ? `JDHP_SEL_DR : `JDHP_RTI;
                `JDHP_SEL_DR: tap_next = tms ? `JDHP_SEL_IR : `JDHP_CAP_DR;
                `JDHP_CAP_DR: tap_next = tms ? `JDHP_EX1_DR : `JDHP_SH_DR;
                `JDHP_SH_DR:  tap_next = tms ? `JDHP_EX1_DR : `JDHP_SH_DR;
                `JDHP_EX1_DR: tap_next = tms ? `JDHP_UP_DR  : `JDHP_PA_DR;
                `JDHP_PA_DR:  tap_next = tms ? `JDHP_EX2_DR : `JDHP_PA_DR;
                `JDHP_EX2_DR: tap_next = tms ? `JDHP_UP_DR  : `JDHP_SH_DR;
                `JDHP_UP_DR:  tap_next = tms ? `JDHP_SEL_DR : `JDHP_RTI;
                `JDHP_SEL_IR: tap_next = tms ? `JDHP_TLR    : `JDHP_CAP_IR;
                `JDHP_CAP_IR: tap_next = tms ? `JDHP_EX1_IR : `JDHP_SH_IR;
                `JDHP_SH_IR:  tap_next = tms ? `JDHP_EX1_IR : `JDHP_SH_IR;
                `JDHP_EX1_IR: tap_next = tms ? `JDHP_UP_IR  : `JDHP_PA_IR;
                `JDHP_PA_IR:  tap_next = tms ? `JDHP_EX2_IR : `JDHP_PA_IR;
                `JDHP_EX2_IR: tap_next = tms ? `JDHP_UP_IR  : `JDHP_SH_IR;
                `JDHP_UP_IR:  tap_next = tms ? `JDHP_SEL_DR : `JDHP_RTI;
                default:      tap_next = `JDHP_TLR;
            endcase
        end
    endfunction

    // shift right by one, new bit enters at position len-1
    function [31:0] shift_in;
        input [31:0] sr;
        input        din;
        input [5:0]  len;
        integer      i;
        begin
            shift_in = 32'h0000_0000;
            for (i = 0; i < 32; i = i + 1) begin
                if (i == len - 1)
                    shift_in[i] = din;
                else if (i < len - 1)
                    shift_in[i] = sr[i + 1];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // synchronisers and tck edges
    // ------------------------------------------------------------------
    reg         tck_s1_reg, tck_s2_reg, tck_s3_reg;
    reg         tms_s1_reg, tms_s2_reg;
    reg         tdi_s1_reg, tdi_s2_reg;
    reg         edr_s1_reg, edr_s2_reg;

    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            tck_s1_reg <= 1'b0;
            tck_s2_reg <= 1'b0;
            tck_s3_reg <= 1'b0;
            tms_s1_reg <= 1'b1;
            tms_s2_reg <= 1'b1;
            tdi_s1_reg <= 1'b0;
            tdi_s2_reg <= 1'b0;
            edr_s1_reg <= 1'b0;
            edr_s2_reg <= 1'b0;
        end else begin
            tck_s1_reg <= tck_i;
            tck_s2_reg <= tck_s1_reg;
            tck_s3_reg <= tck_s2_reg;
            tms_s1_reg <= tms_i;
            tms_s2_reg <= tms_s1_reg;
            tdi_s1_reg <= tdi_i;
            tdi_s2_reg <= tdi_s1_reg;
            edr_s1_reg <= external_debug_request_i;
            edr_s2_reg <= edr_s1_reg;
        end
    end

    wire tck_rise = tck_s2_reg & ~tck_s3_reg;
    wire tck_fall = ~tck_s2_reg & tck_s3_reg;

    // ------------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------------
    reg  [3:0]         tap_reg;
    reg  [3:0]         tap_instruction_register;
    reg  [3:0]         ir_shift_reg;
    reg  [31:0]        dr_shift_reg;
    reg  [3:0]         chain_sel_reg;
    reg                halt_mode_reg;
    reg  [31:0]        itr_reg;
    reg                itr_valid_reg;
    reg  [31:0]        dtr_reg;
    reg                dtr_valid_reg;
    reg  [BSCAN_W-1:0] bscan_out_reg;
    reg                tdo_reg;
    reg                tdo_oe_n_reg;
    reg  [1:0]         core_st_reg;
    reg                core_halted_flag;
    reg                core_restarted_reg;
    reg                debug_state_reg;
    reg                sw_exc_reg;
    reg                tap_test_mode_reg;

    wire [3:0] tap_next_st = tap_next(tap_reg, tms_s2_reg);
    wire       enter_rti   = tck_rise & (tap_next_st == `JDHP_RTI) & (tap_reg != `JDHP_RTI);

    reg        sel_chain;
    reg        sel_select;
    reg        sel_id;
    always @* begin
        sel_chain  = 1'b0;
        sel_select = 1'b0;
        sel_id     = 1'b0;
        case (tap_instruction_register)
            `JDHP_IR_EXTEST:    sel_chain  = 1'b1;
            `JDHP_IR_INTEST:    sel_chain  = 1'b1;
            `JDHP_IR_CHAIN_SEL: sel_select = 1'b1;
            `JDHP_IR_IDCODE:    sel_id     = 1'b1;
            default:            sel_chain  = 1'b0;
        endcase
    end

    wire is_extest = (tap_instruction_register == `JDHP_IR_EXTEST);
    wire is_intest = (tap_instruction_register == `JDHP_IR_INTEST);

    wire [31:0] debug_status_control_reg_word;
    assign debug_status_control_reg_word = (32'h0000_0001 << `JDHP_DEBUG_STATUS_CONTROL_REG_HALTED) & {32{core_halted_flag}}
                     | (32'h0000_0001 << `JDHP_DEBUG_STATUS_CONTROL_REG_RESTARTED) & {32{core_restarted_reg}}
                     | (32'h0000_0001 << `JDHP_DEBUG_STATUS_CONTROL_REG_HALT_EN) & {32{halt_mode_reg}};

    wire [31:0] bscan_cap = {{(32-BSCAN_W){1'b0}}, bscan_in_i};

    reg  [5:0]  dr_len;
    reg  [31:0] dr_cap;
    always @* begin
        dr_len = `JDHP_LEN_BYPASS;
        dr_cap = 32'h0000_0000;
        if (sel_id) begin
            dr_len = `JDHP_LEN_WORD;
            dr_cap = IDCODE_VALUE;
        end else if (sel_select) begin
            dr_len = `JDHP_LEN_SEL;
            dr_cap = {28'h000_0000, `JDHP_CHAIN_SEL_CAP};
        end else if (sel_chain) begin
            case (chain_sel_reg)
                `JDHP_CHAIN_DBG_ID: begin
                    dr_len = `JDHP_LEN_WORD;
                    dr_cap = DEBUG_ID_VALUE;
                end
                `JDHP_CHAIN_DEBUG_STATUS_CONTROL_REG: begin
                    dr_len = `JDHP_LEN_WORD;
                    dr_cap = debug_status_control_reg_word;
                end
                `JDHP_CHAIN_BSCAN: begin
                    dr_len = BSCAN_LEN;
                    dr_cap = bscan_cap;
                end
                `JDHP_CHAIN_ITR: begin
                    dr_len = `JDHP_LEN_WORD;
                    dr_cap = itr_reg;
                end
                `JDHP_CHAIN_DTR: begin
                    dr_len = `JDHP_LEN_WORD;
                    dr_cap = dtr_core_data_i;
                end
                default: begin
                    dr_len = `JDHP_LEN_BYPASS;
                    dr_cap = 32'h0000_0000;
                end
            endcase
        end
    end

    // intest drops tdi so captured chain contents are never disturbed
    wire shift_bit = (sel_chain & is_intest) ? 1'b0 : tdi_s2_reg;

    // ------------------------------------------------------------------
    // tap controller, shift paths and chain updates
    // ------------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            tap_reg                  <= `JDHP_TLR;
            tap_instruction_register <= `JDHP_IR_IDCODE;
            ir_shift_reg             <= `JDHP_IR_CAPTURE;
            dr_shift_reg             <= 32'h0000_0000;
            chain_sel_reg            <= `JDHP_CHAIN_RESET;
            halt_mode_reg            <= 1'b0;
            itr_reg                  <= 32'h0000_0000;
            itr_valid_reg            <= 1'b0;
            dtr_reg                  <= 32'h0000_0000;
            dtr_valid_reg            <= 1'b0;
            bscan_out_reg            <= {BSCAN_W{1'b0}};
            tdo_reg                  <= 1'b0;
            tdo_oe_n_reg             <= 1'b1;
        end else begin
            itr_valid_reg <= 1'b0;
            dtr_valid_reg <= 1'b0;
            if (tck_rise) begin
                tap_reg <= tap_next_st;
                case (tap_reg)
                    `JDHP_TLR: begin
                        tap_instruction_register <= `JDHP_IR_IDCODE;
                        chain_sel_reg            <= `JDHP_CHAIN_RESET;
                    end
                    `JDHP_CAP_IR: ir_shift_reg <= `JDHP_IR_CAPTURE;
                    `JDHP_SH_IR:  ir_shift_reg <= {tdi_s2_reg, ir_shift_reg[3:1]};
                    `JDHP_UP_IR:  tap_instruction_register <= ir_shift_reg;
                    `JDHP_CAP_DR: dr_shift_reg <= dr_cap;
                    `JDHP_SH_DR:  dr_shift_reg <= shift_in(dr_shift_reg, shift_bit, dr_len);
                    `JDHP_UP_DR: begin
                        if (sel_select)
                            chain_sel_reg <= dr_shift_reg[3:0];
                        else if (sel_chain && is_extest) begin
                            case (chain_sel_reg)
                                `JDHP_CHAIN_DEBUG_STATUS_CONTROL_REG:
                                    halt_mode_reg <= dr_shift_reg[`JDHP_DEBUG_STATUS_CONTROL_REG_HALT_EN];
                                `JDHP_CHAIN_BSCAN:
                                    bscan_out_reg <= dr_shift_reg[BSCAN_W-1:0];
                                `JDHP_CHAIN_ITR: begin
                                    itr_reg       <= dr_shift_reg;
                                    itr_valid_reg <= 1'b1;
                                end
                                `JDHP_CHAIN_DTR: begin
                                    dtr_reg       <= dr_shift_reg;
                                    dtr_valid_reg <= 1'b1;
                                end
                                default: ;
                            endcase
                        end
                    end
                    default: ;
                endcase
            end
            if (tck_fall) begin
                tdo_oe_n_reg <= ~((tap_reg == `JDHP_SH_IR) | (tap_reg == `JDHP_SH_DR));
                tdo_reg      <= (tap_reg == `JDHP_SH_IR) ? ir_shift_reg[0] : dr_shift_reg[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // core debug state
    // ------------------------------------------------------------------
    wire core_event = vector_catch_i | reg_breakpoint_hit_i | watchpoint_hit_i
                    | breakpoint_instruction_i | edr_s2_reg;
    // instruction loaded on this same tck rise counts for the idle entry
    wire [3:0] ir_eff = (tap_reg == `JDHP_UP_IR) ? ir_shift_reg : tap_instruction_register;
    wire halt_cmd    = enter_rti & (ir_eff == `JDHP_IR_HALT);
    wire restart_cmd = enter_rti & (ir_eff == `JDHP_IR_RESTART);

    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            core_st_reg        <= `JDHP_CORE_RUN;
            core_halted_flag   <= 1'b0;
            core_restarted_reg <= 1'b0;
            debug_state_reg    <= 1'b0;
            sw_exc_reg         <= 1'b0;
        end else begin
            sw_exc_reg <= 1'b0;
            case (core_st_reg)
                `JDHP_CORE_RUN: begin
                    if (halt_mode_reg && (core_event || halt_cmd)) begin
                        core_st_reg        <= `JDHP_CORE_HALTED;
                        core_halted_flag   <= 1'b1;
                        core_restarted_reg <= 1'b0;
                        debug_state_reg    <= 1'b1;
                    end else if (!halt_mode_reg && core_event)
                        sw_exc_reg <= 1'b1;
                end
                `JDHP_CORE_HALTED: begin
                    if (restart_cmd) begin
                        core_st_reg      <= `JDHP_CORE_RESTART;
                        core_halted_flag <= 1'b0;
                    end
                end
                `JDHP_CORE_RESTART: begin
                    core_st_reg        <= `JDHP_CORE_RUN;
                    debug_state_reg    <= 1'b0;
                    core_restarted_reg <= 1'b1;
                end
                default: core_st_reg <= `JDHP_CORE_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign tdo_o             = tdo_reg;
    assign tdo_oe_n_o        = tdo_oe_n_reg;
    assign bscan_out_o       = bscan_out_reg;
    assign bscan_test_mode_o = tap_test_mode_reg;
    assign debug_state_o     = debug_state_reg;
    assign sw_exception_o    = sw_exc_reg;
    assign itr_data_o        = itr_reg;
    assign itr_valid_o       = itr_valid_reg;
    assign dtr_data_o        = dtr_reg;
    assign dtr_valid_o       = dtr_valid_reg;

    // scan cells in test mode under extest or intest, system mode otherwise
    always @(posedge sys_clk_i) begin
        if (!reset_n_i)
            tap_test_mode_reg <= 1'b0;
        else
            tap_test_mode_reg <= is_extest | is_intest;
    end

endmodule

// ---- rtl/jdhp_defs.vh ----
// constants for the debug test access port with halt mode
`ifndef JDHP_DEFS_VH
`define JDHP_DEFS_VH

// ----------------------------------------------------------------------
// tap controller states
// ----------------------------------------------------------------------
`define JDHP_TLR        4'h0
`define JDHP_RTI        4'h1
`define JDHP_SEL_DR     4'h2
`define JDHP_CAP_DR     4'h3
`define JDHP_SH_DR      4'h4
`define JDHP_EX1_DR     4'h5
`define JDHP_PA_DR      4'h6
`define JDHP_EX2_DR     4'h7
`define JDHP_UP_DR      4'h8
`define JDHP_SEL_IR     4'h9
`define JDHP_CAP_IR     4'hA
`define JDHP_SH_IR      4'hB
`define JDHP_EX1_IR     4'hC
`define JDHP_PA_IR      4'hD
`define JDHP_EX2_IR     4'hE
`define JDHP_UP_IR      4'hF

// ----------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------
`define JDHP_IR_EXTEST      4'h0
`define JDHP_IR_CHAIN_SEL   4'h2
`define JDHP_IR_SAMPLE      4'h3
`define JDHP_IR_RESTART     4'h4
`define JDHP_IR_CLAMP       4'h5
`define JDHP_IR_HIGHZ       4'h7
`define JDHP_IR_HALT        4'h8
`define JDHP_IR_CLAMP_FLOAT 4'h9
`define JDHP_IR_INTEST      4'hC
`define JDHP_IR_IDCODE      4'hE
`define JDHP_IR_BYPASS      4'hF
`define JDHP_IR_CAPTURE     4'h1

// ----------------------------------------------------------------------
// scan chains and lengths
// ----------------------------------------------------------------------
`define JDHP_CHAIN_DBG_ID   4'h0
`define JDHP_CHAIN_DEBUG_STATUS_CONTROL_REG     4'h1
`define JDHP_CHAIN_BSCAN    4'h3
`define JDHP_CHAIN_ITR      4'h4
`define JDHP_CHAIN_DTR      4'h5
`define JDHP_CHAIN_RESET    4'h3
`define JDHP_CHAIN_SEL_CAP  4'h8
`define JDHP_LEN_WORD       6'h20
`define JDHP_LEN_SEL        6'h04
`define JDHP_LEN_BYPASS     6'h01

// ----------------------------------------------------------------------
// debug status and control fields
// ----------------------------------------------------------------------
`define JDHP_DEBUG_STATUS_CONTROL_REG_HALTED    0
`define JDHP_DEBUG_STATUS_CONTROL_REG_RESTARTED 1
`define JDHP_DEBUG_STATUS_CONTROL_REG_HALT_EN   30

// ----------------------------------------------------------------------
// core debug states
// ----------------------------------------------------------------------
`define JDHP_CORE_RUN       2'h0
`define JDHP_CORE_HALTED    2'h1
`define JDHP_CORE_RESTART   2'h2

`endif

// ---- sim/jdhp_tap_chk.sv ----
// assertion checker for the debug test access port
`timescale 1ns/1ps
module jdhp_tap_chk #(
    parameter BSCAN_W = 8
) (
    input wire               sys_clk_i,
    input wire               reset_n_i,
    input wire               tck_i,
    input wire               tdo_o,
    input wire               tdo_oe_n_o,
    input wire               external_debug_request_i,
    input wire               vector_catch_i,
    input wire               reg_breakpoint_hit_i,
    input wire               watchpoint_hit_i,
    input wire               breakpoint_instruction_i,
    input wire [BSCAN_W-1:0] bscan_out_o,
    input wire               bscan_test_mode_o,
    input wire               debug_state_o,
    input wire               sw_exception_o,
    input wire               itr_valid_o,
    input wire               dtr_valid_o
);
    wire evt = vector_catch_i | reg_breakpoint_hit_i | watchpoint_hit_i
               | breakpoint_instruction_i;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_evt_out; !debug_state_o && evt |=> debug_state_o ^ sw_exception_o; endproperty
    a_evt_out: assert property (p_evt_out)
        else $error("event gave neither halt nor exception");
    property p_exc_cause; sw_exception_o |-> $past(evt) || $past(external_debug_request_i, 3);
    endproperty
    a_exc_cause: assert property (p_exc_cause)
        else $error("exception without event");
    property p_exc_run; sw_exception_o |-> !debug_state_o; endproperty
    a_exc_run: assert property (p_exc_run)
        else $error("exception while halted");
    property p_itr_mode; itr_valid_o |-> bscan_test_mode_o; endproperty
    a_itr_mode: assert property (p_itr_mode)
        else $error("itr written outside test mode");
    property p_dtr_mode; dtr_valid_o |-> bscan_test_mode_o; endproperty
    a_dtr_mode: assert property (p_dtr_mode)
        else $error("dtr written outside test mode");
    property p_itr_pulse; itr_valid_o |=> !itr_valid_o; endproperty
    a_itr_pulse: assert property (p_itr_pulse)
        else $error("itr valid longer than one cycle");
    property p_tdo_fall; $changed(tdo_o) |-> !$past(tck_i); endproperty
    a_tdo_fall: assert property (p_tdo_fall)
        else $error("tdo moved while tck high");
    property p_oe_fall; $changed(tdo_oe_n_o) |-> !$past(tck_i); endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("tdo enable moved while tck high");
    property p_bscan_mode; $changed(bscan_out_o) |-> bscan_test_mode_o; endproperty
    a_bscan_mode: assert property (p_bscan_mode)
        else $error("boundary outputs moved outside test mode");
endmodule
bind jdhp_tap jdhp_tap_chk #(.BSCAN_W(BSCAN_W)) i_jdhp_tap_chk (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .tck_i(tck_i), .tdo_o(tdo_o),
    .tdo_oe_n_o(tdo_oe_n_o), .external_debug_request_i(external_debug_request_i),
    .vector_catch_i(vector_catch_i), .reg_breakpoint_hit_i(reg_breakpoint_hit_i),
    .watchpoint_hit_i(watchpoint_hit_i), .breakpoint_instruction_i(breakpoint_instruction_i),
    .bscan_out_o(bscan_out_o), .bscan_test_mode_o(bscan_test_mode_o),
    .debug_state_o(debug_state_o), .sw_exception_o(sw_exception_o),
    .itr_valid_o(itr_valid_o), .dtr_valid_o(dtr_valid_o));

// ---- sim/jdhp_probe.sv ----
// behavioural debug probe driving the test port pins
`timescale 1ns/1ps
module jdhp_probe (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input  wire  tdo_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // one 800 ns test clock; tck stands low between calls
    task automatic step(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        #400 tck_o = 1'b1;
        q = tdo_i;
        #400 tck_o = 1'b0;
    endtask
    task automatic reset_tap();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
    // scan from idle back to idle; never while the core writes
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic q;
        dout = 32'h0000_0000;
        step(1'b1, 1'b0, q);
        if (ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~din[n - 1], q);
        step(1'b0, ~din[n - 1], q);
    endtask
endmodule

// ---- sim/tb_jdhp_tap.sv ----
// self-checking bench for the debug test access port
`timescale 1ns/1ps
module tb_jdhp_tap;
    localparam [31:0] ID_VAL = 32'h1000_0001; // arbitrary value
    logic        sys_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        vc = 1'b0, rbp = 1'b0, wp = 1'b0, breakpoint_instruction = 1'b0, edr = 1'b0;
    logic [31:0] dtr_core = 32'h5A5A_0F0F;
    logic [31:0] rd;
    logic [7:0]  bscan_in = 8'hA5;
    logic [3:0]  byp [12] = '{4'hF, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA,
                              4'hB, 4'hD};
    wire         tck, tms, tdi, tdo, oe_n, bmode, dbg, sw_exc, itr_v, dtr_v;
    wire         tdo_pin = oe_n ? 1'b1 : tdo; // released tdo floats to its pull-up
    wire  [31:0] itr_data, dtr_data;
    wire  [7:0]  bscan_out;
    int          err_count = 0, n_tests = 0, cyc = 0;
    jdhp_probe i_jdhp_probe (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_pin));
    jdhp_tap #(.IDCODE_VALUE(ID_VAL)) i_jdhp_tap (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_n_o(oe_n), .external_debug_request_i(edr), .vector_catch_i(vc),
        .reg_breakpoint_hit_i(rbp), .watchpoint_hit_i(wp), .breakpoint_instruction_i(breakpoint_instruction),
        .dtr_core_data_i(dtr_core), .bscan_in_i(bscan_in), .bscan_out_o(bscan_out),
        .bscan_test_mode_o(bmode), .debug_state_o(dbg), .sw_exception_o(sw_exc),
        .itr_data_o(itr_data), .itr_valid_o(itr_v), .dtr_data_o(dtr_data),
        .dtr_valid_o(dtr_v));
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            $display("ERROR %0t timeout", $time);
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sc(input logic ir, input logic [31:0] din, input int n);
        i_jdhp_probe.scan(ir, din, n, rd);
        repeat (4) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic sel(input logic [3:0] c);
        sc(1'b1, 32'h0000_0002, 4);
        sc(1'b0, {28'h0, c}, 4);
        chk(rd, 32'h0000_0008);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_i);
        #1 reset_n_i = 1'b1;
        i_jdhp_probe.reset_tap();
        sc(1'b0, 32'h0000_0000, 32);
        chk(rd, ID_VAL);
        foreach (byp[k]) begin
            sc(1'b1, {28'h0, byp[k]}, 4);
            chk(rd, 32'h0000_0001);
            sc(1'b0, 32'h0000_0001, 2);
            chk(rd, 32'h0000_0002);
        end
        chk(dbg, 1'b0);
        sc(1'b1, 32'h0000_0000, 4);
        chk(bmode, 1'b1);
        sc(1'b0, 32'h0000_003C, 8);
        chk(rd, 32'h0000_00A5);
        chk({24'h0, bscan_out}, 32'h0000_003C);
        @(posedge sys_clk_i) #1 vc = 1'b1;
        @(posedge sys_clk_i) #1 vc = 1'b0;
        chk(sw_exc, 1'b1);
        @(posedge sys_clk_i) #1 {rbp, breakpoint_instruction} = 2'b10;
        @(posedge sys_clk_i) #1 {rbp, breakpoint_instruction} = 2'b01;
        chk(sw_exc, 1'b1);
        @(posedge sys_clk_i) #1 breakpoint_instruction = 1'b0;
        chk(sw_exc, 1'b1);
        @(posedge sys_clk_i) #1 edr = 1'b1;
        @(posedge sys_clk_i) #1 edr = 1'b0;
        @(posedge sys_clk_i);
        @(posedge sys_clk_i) #1 chk(sw_exc, 1'b1);
        @(posedge sys_clk_i) #1 chk(sw_exc, 1'b0);
        sel(4'h1);
        sc(1'b1, 32'h0000_0000, 4);
        sc(1'b0, 32'h4000_0000, 32);
        sc(1'b1, 32'h0000_0008, 4);
        chk(dbg, 1'b1);
        sc(1'b1, 32'h0000_000C, 4);
        sc(1'b0, 32'hFFFF_FFFF, 32);
        chk(rd, 32'h4000_0001);
        sel(4'h4);
        sc(1'b1, 32'h0000_0000, 4);
        sc(1'b0, 32'h1234_5678, 32);
        chk(itr_data, 32'h1234_5678);
        sc(1'b1, 32'h0000_000C, 4);
        sc(1'b0, 32'hFFFF_FFFF, 32);
        chk(rd, 32'h1234_5678);
        chk(itr_data, 32'h1234_5678);
        sel(4'h5);
        sc(1'b1, 32'h0000_000C, 4);
        sc(1'b0, 32'h0000_0000, 32);
        chk(rd, dtr_core);
        sc(1'b1, 32'h0000_0000, 4);
        sc(1'b0, 32'h0BAD_F00D, 32);
        chk(dtr_data, 32'h0BAD_F00D);
        sel(4'h2);
        sc(1'b1, 32'h0000_000C, 4);
        sc(1'b0, 32'h0000_0003, 2);
        chk(rd, 32'h0000_0000);
        sel(4'h1);
        sc(1'b1, 32'h0000_0004, 4);
        chk(dbg, 1'b0);
        sc(1'b1, 32'h0000_000C, 4);
        sc(1'b0, 32'h0000_0000, 32);
        chk(rd, 32'h4000_0002);
        @(posedge sys_clk_i) #1 wp = 1'b1;
        @(posedge sys_clk_i) #1 wp = 1'b0;
        @(posedge sys_clk_i) #1 chk(dbg, 1'b1);
        give_verdict();
    end
endmodule
